// ---- bzcd_pkg.sv ----
/*
  Shared constants, register map and types of the back-EMF zero-crossing and
  demagnetization detector.
  Assumes a single 20 MHz clock and a plain address/strobe register port.
*/
package bzcd_pkg;

  // clock and window timing
  localparam int CLK_PERIOD_NS      = 50;
  localparam int WIN_SHORT_STEP_NS  = 5000;
  localparam int WIN_LONG_STEP_NS   = 20000;
  localparam int WIN_SHORT_STEP_CYC = (WIN_SHORT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_LONG_STEP_CYC  = (WIN_LONG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_SHORT_CODES    = 8;
  localparam int WIN_CNT_W          = 12;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_ZCF_OFS    = 8'h04;
  localparam logic [7:0] REG_DMF_OFS    = 8'h08;
  localparam logic [7:0] REG_DVAL_OFS   = 8'h0c;
  localparam logic [7:0] REG_STAT_OFS   = 8'h10;
  localparam logic [7:0] REG_MASK_OFS   = 8'h14;
  localparam logic [7:0] REG_CMD_OFS    = 8'h18;

  // field positions
  localparam int STAT_DEMAG_BIT = 0;
  localparam int STAT_ZC_BIT    = 1;
  localparam int STAT_PHASE_LSB = 4;
  localparam int MASK_DEMAG_BIT = 0;
  localparam int MASK_ZC_BIT    = 1;
  localparam int CMD_COMM_BIT   = 0;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'h0f;

  typedef struct packed {
    logic [2:0] sample_clock_freq;
    logic       alt_speed_mode_bit;
    logic       comparator_edge_sel;
    logic       zc_polarity_sel;
    logic       sim_demag_enable;
    logic       hw_demag_enable;
  } bzcd_ctrl_s;

  typedef struct packed {
    logic [3:0] event_limit;
    logic [3:0] window_len;
  } bzcd_filt_s;

  typedef enum logic [1:0] {
    PH_WAIT_D = 2'b00,
    PH_WAIT_Z = 2'b01,
    PH_WAIT_C = 2'b10
  } bzcd_phase_e;

  // window length in clock cycles for a 4-bit window code
  function automatic logic [WIN_CNT_W-1:0] bzcd_win_cycles(input logic [3:0] code);
    int cyc;
    cyc = 0;
    if (!code[3])
      cyc = (int'(code) + 1) * WIN_SHORT_STEP_CYC;
    else
      cyc = WIN_SHORT_CODES * WIN_SHORT_STEP_CYC + (int'(code) - 7) * WIN_LONG_STEP_CYC;
    return WIN_CNT_W'(cyc);
  endfunction

endpackage

// ---- bzcd_sample_div.sv ----
/*
  Sample-rate divider: one-cycle enable pulse every 2**sel clock cycles.
  Assumes sel is static or changes rarely; a change takes effect at once.
*/
module bzcd_sample_div (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // rate select and tick
  input  wire logic [2:0] sel,
  output logic            tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } bzcd_div_s;

  bzcd_div_s  s_r;
  bzcd_div_s  s_nxt;
  logic [8:0] span;

  always_comb
  begin
    s_nxt = s_r;
    span  = (9'h001 << sel) - 9'h001;
    if (s_r.cnt >= span[7:0])
    begin
      s_nxt.cnt  = 8'h00;
      s_nxt.tick = 1'b1;
    end
    else
    begin
      s_nxt.cnt  = s_r.cnt + 8'h01;
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

endmodule // bzcd_sample_div

// ---- bzcd_event_filter.sv ----
/*
  Blanking window followed by a consecutive-event counter; used for both
  the demagnetization and the zero-crossing detector.
  Assumes match/edge_ok are evaluated in the cycle of sample_en.
*/
module bzcd_event_filter (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // control
  input  wire logic       restart,
  input  wire logic       arm,
  input  wire logic       no_window,
  input  wire logic [3:0] window_len,
  input  wire logic [3:0] event_limit,
  // samples
  input  wire logic       sample_en,
  input  wire logic       match,
  input  wire logic       edge_ok,
  // result
  output logic            fired
);

  typedef struct packed {
    logic [bzcd_pkg::WIN_CNT_W-1:0] win_cnt;
    logic [3:0]                     hits;
    logic                           fired;
  } bzcd_flt_s;

  bzcd_flt_s s_r;
  bzcd_flt_s s_nxt;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.fired = 1'b0;
    if (restart)
    begin
      // alternate mode has no blanking at all
      s_nxt.win_cnt = no_window ? '0 : bzcd_pkg::bzcd_win_cycles(window_len);  // see R01 R03 R19 R21
      s_nxt.hits    = 4'h0;  // see R20
    end
    else if (s_r.win_cnt != '0)
      s_nxt.win_cnt = s_r.win_cnt - 1'b1;
    else if (arm && sample_en)  // see R06
    begin
      // first hit must follow an opposite sample, later ones only hold the level
      if (match && (s_r.hits != 4'h0 || edge_ok))
      begin
        if (s_r.hits == event_limit)  // see R04 R05 R10
        begin
          s_nxt.fired = 1'b1;
          s_nxt.hits  = 4'h0;
        end
        else
          s_nxt.hits = s_r.hits + 4'h1;
      end
      else
        s_nxt.hits = 4'h0;  // see R20
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign fired = s_r.fired;

endmodule // bzcd_event_filter

// ---- bzcd_bemf_detect.sv ----
/*
  Sensorless back-EMF event detection: demagnetization (hardware and
  simulated) and zero-crossing events with blanking windows, consecutive
  event filters, edge polarity selection, demag timer capture/compare and a
  masked interrupt request from the demag and zero-crossing flags.
  Assumes commutation pulses, the motor timer and the comparator output are
  synchronous to clock; the timer itself lives outside this block.
*/
// Implementation choices: strobed register access and the placing of the registers.

// Functional notes
// R01 - blank zero crossing after demag, default 200us
// R02 - commutation, hardware or software, restarts blanking
// R03 - window codes 5-40us, 60-200us; none alternate
// R04 - count consecutive zero crossings up to limit
// R05 - limit field encodes count as value plus one
// R06 - comparator sampled at selectable divided rate
// R07 - simulated zero crossing needs one event only
// R08 - two bits select demag and zero-cross polarity
// R09 - hardware demag is edge at selected polarity
// R10 - demag filter counts consecutive hardware detections
// R11 - hardware demag captures timer into value register
// R12 - simulated demag when timer equals value register
// R13 - both enabled: first demag event wins
// R14 - simulated only: compare masks commutation to crossing
// R15 - any demag sets flag, masked interrupt request
// R16 - after commutation, stale value fires demag immediately
// R17 - software handles demag value register carefully
// R18 - events follow commutation, demag, crossing order
// R19 - demag blanking after commutation, default 200us
// R20 - counter restarts on failed sample or commutation
// R21 - windows are clock counts, scale with clock
module bzcd_bemf_detect #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [15:0]        reg_rdata,
  // motor side inputs
  input  wire logic               phase_sense_input,
  input  wire logic               comm_hw_evt,
  input  wire logic               zc_sim_evt,
  input  wire logic [TIMER_W-1:0] motor_timer,
  // events and interrupt
  output logic                    demag_evt,
  output logic                    zc_evt,
  output logic                    motor_irq
);

  if (TIMER_W < 4 || TIMER_W > 16)
  begin : g_bad_width
    $error("bzcd_bemf_detect: TIMER_W must lie in 4..16");
  end

  typedef struct packed {
    bzcd_pkg::bzcd_ctrl_s  motor_ctrl_reg_b;
    bzcd_pkg::bzcd_filt_s  zc_filter_reg;
    bzcd_pkg::bzcd_filt_s  demag_filter_reg;
    logic [TIMER_W-1:0]    demag_value_reg;
    logic                  demag_irq_flag;
    logic                  zc_flag;
    logic                  demag_irq_mask;
    logic                  zc_irq_mask;
    bzcd_pkg::bzcd_phase_e phase;
    logic                  sense_prev;
    logic                  comm_check;
    logic [15:0]           rdata;
    logic                  demag_evt;
    logic                  zc_evt;
    logic                  motor_irq;
  } bzcd_top_s;

  bzcd_top_s s_r;
  bzcd_top_s s_nxt;

  logic sample_tick;
  logic d_fired;
  logic z_fired;

  // combinational event terms
  logic c_evt;
  logic sw_comm;
  logic d_level;
  logic z_level;
  logic in_wait_d;
  logic d_hw;
  logic d_sim_check;
  logic d_sim_match;
  logic d_evt;
  logic z_evt_now;
  logic stat_wr;
  logic [15:0] rd_word;

  bzcd_sample_div u_div (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sel     (s_r.motor_ctrl_reg_b.sample_clock_freq),
    .tick    (sample_tick)
  );

  // demag detector: blanking after each commutation
  bzcd_event_filter u_demag_flt (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .restart     (c_evt),  // see R02 R19
    .arm         (in_wait_d && s_r.motor_ctrl_reg_b.hw_demag_enable),
    .no_window   (s_r.motor_ctrl_reg_b.alt_speed_mode_bit),
    .window_len  (s_r.demag_filter_reg.window_len),
    .event_limit (s_r.demag_filter_reg.event_limit),
    .sample_en   (sample_tick),
    .match       (phase_sense_input == d_level),  // see R09
    .edge_ok     (s_r.sense_prev != d_level),
    .fired       (d_fired)
  );

  // zero-crossing detector: blanking after each demag and commutation
  bzcd_event_filter u_zc_flt (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .restart     (c_evt || d_evt),  // see R01 R02
    .arm         (s_r.phase == bzcd_pkg::PH_WAIT_Z),
    .no_window   (s_r.motor_ctrl_reg_b.alt_speed_mode_bit),
    .window_len  (s_r.zc_filter_reg.window_len),
    .event_limit (s_r.zc_filter_reg.event_limit),
    .sample_en   (sample_tick),
    .match       (phase_sense_input == z_level),
    .edge_ok     (s_r.sense_prev != z_level),
    .fired       (z_fired)
  );

  always_comb
  begin
    sw_comm   = reg_wr && (reg_addr == bzcd_pkg::REG_CMD_OFS) && reg_wdata[bzcd_pkg::CMD_COMM_BIT];
    c_evt     = comm_hw_evt || sw_comm;  // see R02
    // demag level follows the edge bit; crossing is opposite unless inverted
    d_level   = s_r.motor_ctrl_reg_b.comparator_edge_sel;  // see R08
    z_level   = s_r.motor_ctrl_reg_b.zc_polarity_sel ? d_level : ~d_level;  // see R08
    in_wait_d = (s_r.phase == bzcd_pkg::PH_WAIT_D);
    d_hw      = d_fired && in_wait_d && s_r.motor_ctrl_reg_b.hw_demag_enable;  // see R10
    // a stale compare value would never match; it fires once after commutation
    d_sim_check = s_r.comm_check && in_wait_d && s_r.motor_ctrl_reg_b.sim_demag_enable
                  && (s_r.demag_value_reg <= motor_timer);  // see R16
    d_sim_match = !s_r.comm_check && in_wait_d && s_r.motor_ctrl_reg_b.sim_demag_enable
                  && (s_r.demag_value_reg == motor_timer);  // see R12 R14
    // first of hardware or simulated demag wins; commutation outranks both
    d_evt     = !c_evt && (d_hw || d_sim_check || d_sim_match);  // see R13 R18
    z_evt_now = !c_evt && (s_r.phase == bzcd_pkg::PH_WAIT_Z)
                && (z_fired || zc_sim_evt);  // see R07 R18
    stat_wr   = reg_wr && (reg_addr == bzcd_pkg::REG_STAT_OFS);

    rd_word = 16'h0000;
    unique case (reg_addr)
      bzcd_pkg::REG_CTRL_OFS: rd_word = {8'h00, s_r.motor_ctrl_reg_b};
      bzcd_pkg::REG_ZCF_OFS:  rd_word = {8'h00, s_r.zc_filter_reg};
      bzcd_pkg::REG_DMF_OFS:  rd_word = {8'h00, s_r.demag_filter_reg};
      bzcd_pkg::REG_DVAL_OFS: rd_word = 16'(s_r.demag_value_reg);
      bzcd_pkg::REG_STAT_OFS:
      begin
        rd_word[bzcd_pkg::STAT_DEMAG_BIT]                           = s_r.demag_irq_flag;
        rd_word[bzcd_pkg::STAT_ZC_BIT]                              = s_r.zc_flag;
        rd_word[bzcd_pkg::STAT_PHASE_LSB+1:bzcd_pkg::STAT_PHASE_LSB] = s_r.phase;
      end
      bzcd_pkg::REG_MASK_OFS:
      begin
        rd_word[bzcd_pkg::MASK_DEMAG_BIT] = s_r.demag_irq_mask;
        rd_word[bzcd_pkg::MASK_ZC_BIT]    = s_r.zc_irq_mask;
      end
      default: rd_word = 16'h0000;
    endcase

    s_nxt           = s_r;
    s_nxt.demag_evt = d_evt;
    s_nxt.zc_evt    = z_evt_now;
    s_nxt.rdata     = reg_rd ? rd_word : 16'h0000;

    if (sample_tick)
      s_nxt.sense_prev = phase_sense_input;

    // software writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        bzcd_pkg::REG_CTRL_OFS: s_nxt.motor_ctrl_reg_b = reg_wdata[7:0];
        bzcd_pkg::REG_ZCF_OFS:  s_nxt.zc_filter_reg    = reg_wdata[7:0];
        bzcd_pkg::REG_DMF_OFS:  s_nxt.demag_filter_reg = reg_wdata[7:0];
        bzcd_pkg::REG_DVAL_OFS: s_nxt.demag_value_reg  = reg_wdata[TIMER_W-1:0];  // see R17
        bzcd_pkg::REG_MASK_OFS:
        begin
          s_nxt.demag_irq_mask = reg_wdata[bzcd_pkg::MASK_DEMAG_BIT];
          s_nxt.zc_irq_mask    = reg_wdata[bzcd_pkg::MASK_ZC_BIT];
        end
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end

    // status flags: write one to clear, a same-cycle event keeps the flag set
    if (stat_wr && reg_wdata[bzcd_pkg::STAT_DEMAG_BIT])
      s_nxt.demag_irq_flag = 1'b0;
    if (stat_wr && reg_wdata[bzcd_pkg::STAT_ZC_BIT])
      s_nxt.zc_flag = 1'b0;
    if (d_evt)
      s_nxt.demag_irq_flag = 1'b1;  // see R15
    if (z_evt_now)
      s_nxt.zc_flag = 1'b1;  // see R04

    // hardware update of the demag value outranks a software write
    if (d_hw)
      s_nxt.demag_value_reg = motor_timer;  // see R11
    else if (d_sim_check)
      s_nxt.demag_value_reg = motor_timer;  // see R16

    // one compare-check cycle right after every commutation
    s_nxt.comm_check = c_evt;

    // event sequencing
    if (c_evt)
      s_nxt.phase = bzcd_pkg::PH_WAIT_D;  // see R18
    else if (d_evt)
      s_nxt.phase = bzcd_pkg::PH_WAIT_Z;
    else if (z_evt_now)
      s_nxt.phase = bzcd_pkg::PH_WAIT_C;

    s_nxt.motor_irq = (s_nxt.demag_irq_flag && s_nxt.demag_irq_mask)
                      || (s_nxt.zc_flag && s_nxt.zc_irq_mask);  // see R15
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_r                  <= '0;
      s_r.motor_ctrl_reg_b <= bzcd_pkg::CTRL_RST;
      s_r.zc_filter_reg    <= bzcd_pkg::FILT_RST;  // see R01 R04
      s_r.demag_filter_reg <= bzcd_pkg::FILT_RST;  // see R19
      s_r.phase            <= bzcd_pkg::PH_WAIT_C;
    end
    else
      s_r <= s_nxt;
  end

  assign reg_rdata = s_r.rdata;
  assign demag_evt = s_r.demag_evt;
  assign zc_evt    = s_r.zc_evt;
  assign motor_irq = s_r.motor_irq;

endmodule // bzcd_bemf_detect

// ---- bzcd_assertions.sv ----
/*
  Port checker for bzcd_bemf_detect, bound to every instance.
  Assumes one clock and the synchronous active-high reset.
*/
module bzcd_checker (
  // clock, reset and register port
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // motor events
  input wire logic        comm_hw_evt,
  input wire logic        demag_evt,
  input wire logic        zc_evt,
  input wire logic        motor_irq
);
  logic comm_any;
  logic d_seen_r;
  logic d_seen_nxt;

  // software commutation counts as a step as well
  assign comm_any = comm_hw_evt | (reg_wr & (reg_addr == bzcd_pkg::REG_CMD_OFS)
                                   & reg_wdata[bzcd_pkg::CMD_COMM_BIT]);

  always_comb
  begin
    d_seen_nxt = comm_any ? 1'b0 : (demag_evt | d_seen_r);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      d_seen_r <= 1'b0;
    else
      d_seen_r <= d_seen_nxt;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside read slot");
  demag_pulse_a: assert property (
    demag_evt |=> !demag_evt) else $error("demag event longer than one cycle");
  zc_pulse_a: assert property (
    zc_evt |=> !zc_evt) else $error("zero crossing event longer than one cycle");
  comm_cancel_a: assert property (
    comm_any |=> !demag_evt && !zc_evt ##1 !zc_evt) else $error("event survived a commutation");
  zc_order_a: assert property (
    zc_evt |-> d_seen_r) else $error("zero crossing before demag");
  demag_once_a: assert property (
    demag_evt |-> !d_seen_r) else $error("second demag in one step");
  // flag, event pulse and interrupt all leave the same register stage
  irq_rise_a: assert property (
    $rose(motor_irq) |-> demag_evt || zc_evt || $past(reg_wr))
    else $error("interrupt without cause");
  irq_fall_a: assert property (
    $fell(motor_irq) |-> $past(reg_wr)) else $error("interrupt dropped without write");
endmodule // bzcd_checker

bind bzcd_bemf_detect bzcd_checker chk (
  .clock      (clock),
  .sys_rst    (sys_rst),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .comm_hw_evt(comm_hw_evt),
  .demag_evt  (demag_evt),
  .zc_evt     (zc_evt),
  .motor_irq  (motor_irq)
);

// ---- bzcd_motor_model.sv ----
/*
  Power stage and winding comparator model.
  Assumes kick is a one-cycle request driven just after a clock edge.
*/
module bzcd_motor_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // step request and winding shape
  input  wire logic        kick,
  input  wire logic [15:0] d_len,
  input  wire logic [15:0] z_len,
  // winding side
  output logic             comm_hw_evt,
  output logic             phase_sense_input,
  output logic [15:0]      motor_timer
);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      comm_hw_evt <= 1'b0;
      motor_timer <= 16'h0000;
    end
    else
    begin
      comm_hw_evt <= kick;
      motor_timer <= kick ? 16'h0000 : motor_timer + 16'h0001;
    end
  end

  // rail while freewheeling, low until the crossing, then high
  assign phase_sense_input = (motor_timer < d_len) || (motor_timer >= z_len);
endmodule // bzcd_motor_model

// ---- testbench.sv ----
/*
  Self-checking bench for bzcd_bemf_detect driven by a motor model.
  Assumes sample_clock_freq 0, so the comparator is sampled every clock,
  except in the one slow-sampling case near the end.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

  logic        clock;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        zc_sim_evt;
  logic        kick;
  logic [15:0] d_len;
  logic [15:0] z_len;
  logic        comm_hw_evt;
  logic        phase_sense_input;
  logic [15:0] motor_timer;
  logic        demag_evt;
  logic        zc_evt;
  logic        motor_irq;
  logic [15:0] v;
  logic [15:0] td;
  logic [15:0] tz;
  logic [15:0] off;
  int          n_mismatch;
  int          checks_done;
  // address, reset value
  logic [23:0] rows [8] = '{24'h000000, 24'h04000f, 24'h08000f, 24'h0c0000,
                            24'h100020, 24'h140000, 24'h180000, 24'h1c0000};

  bzcd_motor_model model (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .kick             (kick),
    .d_len            (d_len),
    .z_len            (z_len),
    .comm_hw_evt      (comm_hw_evt),
    .phase_sense_input(phase_sense_input),
    .motor_timer      (motor_timer)
  );

  bzcd_bemf_detect dut (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .phase_sense_input(phase_sense_input),
    .comm_hw_evt      (comm_hw_evt),
    .zc_sim_evt       (zc_sim_evt),
    .motor_timer      (motor_timer),
    .demag_evt        (demag_evt),
    .zc_evt           (zc_evt),
    .motor_irq        (motor_irq)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    @(posedge clock);
  endtask

  // pre-edge values at the second edge are the read slot
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask

  // one step; timer value at the first demag and zero crossing pulse
  task automatic run(input int lim, input logic zs, output logic [15:0] d, output logic [15:0] z);
    d = 16'hffff;
    z = 16'hffff;
    kick <= 1'b1;
    repeat (lim)
    begin
      @(posedge clock);
      kick       <= 1'b0;
      zc_sim_evt <= zs && demag_evt === 1'b1;
      if (d === 16'hffff && demag_evt === 1'b1)
        d = motor_timer;
      if (z === 16'hffff && zc_evt === 1'b1)
        z = motor_timer;
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    #1000000;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, zc_sim_evt, kick} = '0;
    d_len   = 16'd300;
    z_len   = 16'd600;
    sys_rst = 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      rd(rows[i][23:16], v);
      `CHK(v, rows[i][15:0])
    end
    wr(8'h00, 16'h0001); // zero-cross polarity kept 0
    wr(8'h08, 16'h0000);
    wr(8'h04, 16'h0020);
    wr(8'h14, 16'h0001);
    run(800, 1'b0, td, tz);
    off = td - d_len;
    `CHK(off <= 16'd4 && td > d_len, 1'b1)
    `CHK(tz - z_len, off + 16'd2)
    rd(8'h0c, v);
    `CHK(v >= d_len && v <= td, 1'b1)
    `CHK(motor_irq, 1'b1)
    rd(8'h10, v);
    `CHK(v, 16'h0023)
    wr(8'h10, 16'h0001);
    @(posedge clock);
    `CHK(motor_irq, 1'b0)
    wr(8'h04, 16'h0023);
    run(900, 1'b0, td, tz);
    `CHK(tz, 16'hffff)
    wr(8'h18, 16'h0001);
    rd(8'h10, v);
    `CHK(v, 16'h0003)
    d_len <= 16'd200;
    wr(8'h08, 16'h0002);
    run(600, 1'b0, td, tz);
    `CHK(td, 16'hffff)
    wr(8'h00, 16'h0011);
    run(800, 1'b0, td, tz);
    `CHK(td - d_len, off)
    `CHK(tz - z_len, off + 16'd2)
    wr(8'h00, 16'h0002);
    wr(8'h0c, 16'h0000);
    run(50, 1'b1, td, tz);
    `CHK(td, 16'h0002)
    `CHK(tz, 16'h0004)
    rd(8'h0c, v);
    `CHK(v, 16'h0001)
    wr(8'h0c, 16'h0100); // mask past the real demag
    run(400, 1'b0, td, tz);
    `CHK(td, 16'h0101)
    `CHK(motor_irq, 1'b1)
    // reset in mid-run must bring back the defaults
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(8'h04, v);
    `CHK(v, 16'h000f)
    `CHK(motor_irq, 1'b0)
    // zero-cross edge same as demag, sampled every second clock
    wr(8'h00, 16'h0035);
    run(700, 1'b0, td, tz);
    `CHK(td - d_len >= off && td - d_len <= off + 16'd1, 1'b1)
    `CHK(tz, 16'hffff)
    // demag on the rising edge, crossing would need a falling one
    wr(8'h00, 16'h0019);
    run(700, 1'b0, td, tz);
    `CHK(td - z_len, off)
    `CHK(tz, 16'hffff)
    summarize();
  end
endmodule // testbench
